/* File: logic/dac_defs.svh */
// constants for the converter input register and decoder
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

`define DAC_CODE_RST           14'h0000
`define DAC_CLK_PERIOD_NS      100
`define DAC_MIN_RATE_PERIOD_NS 10000
`define DAC_MAX_RATE_PERIOD_NS 10
`define DAC_GAP_TIMEOUT_CYC    ((`DAC_MIN_RATE_PERIOD_NS) / (`DAC_CLK_PERIOD_NS))

`endif

/* File: logic/dac_pkg.sv */
// types for the converter input register and decoder
package dac_pkg;

   typedef enum logic [2:0] {
      DAC_LINK_IDLE  = 3'b001,
      DAC_LINK_RUN   = 3'b010,
      DAC_LINK_STALL = 3'b100
   } dac_link_e;

endpackage

/* File: logic/dac_front.sv */
// input register, ladder drive and thermometer segment decoder
`timescale 1ns/10ps
`default_nettype none
`include "dac_defs.svh"

module dac_front
   import dac_pkg::*;
#(
   parameter int WIDTH       = 14,
   parameter int LADDER_BITS = 10,
   parameter int SEGMENTS    = 15
) (
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   input  wire logic                   data_clk,
   input  wire logic [WIDTH-1:0]       data_in,
   output logic      [WIDTH-1:0]       code_q,
   output logic      [LADDER_BITS-1:0] ladder_q,
   output logic      [SEGMENTS-1:0]    segment_q,
   output logic                        full_scale_q,
   output logic                        mid_scale_q,
   output logic                        zero_scale_q,
   output logic                        link_active_q,
   output logic                        link_stall_q
);

   localparam int SEG_BITS = WIDTH - LADDER_BITS;
   localparam int GAP_MAX  = `DAC_GAP_TIMEOUT_CYC;
   localparam int GAP_W    = $clog2(GAP_MAX + 1);

   localparam logic [WIDTH-1:0]    CODE_ONES = {WIDTH{1'b1}};
   localparam logic [WIDTH-1:0]    CODE_MID  = {1'b1, {(WIDTH-1){1'b0}}};
   localparam logic [GAP_W-1:0]    GAP_LAST  = GAP_W'(GAP_MAX - 1);
   localparam logic [SEGMENTS-1:0] SEG_ONE   = SEGMENTS'(1);

   typedef struct packed {
      dac_link_e              link;
      logic                   clk_prev;
      logic [GAP_W-1:0]       gap_cnt;
      logic [WIDTH-1:0]       master;
      logic [WIDTH-1:0]       code;
      logic [LADDER_BITS-1:0] ladder;
      logic [SEGMENTS-1:0]    segment;
      logic                   full;
      logic                   mid;
      logic                   zero;
   } dac_state_s;

   dac_state_s state_q;
   dac_state_s state_d;
   logic       clk_rise;
   logic [SEG_BITS-1:0] seg_value;

   ////////////////////////////////////////////////////////////////////////
   // next state

   // a data clock held high gives one rise only
   assign clk_rise  = data_clk & ~state_q.clk_prev;
   assign seg_value = state_q.master[WIDTH-1:LADDER_BITS];

   always_comb begin
      state_d          = state_q;
      state_d.clk_prev = data_clk;

      // master stage takes the whole word on the data clock rise
      if (clk_rise) begin
         state_d.master = data_in;
      end

      // only the latched word feeds the switch controls
      state_d.code   = state_q.master;
      state_d.ladder = state_q.master[LADDER_BITS-1:0];
      for (int i = 0; i < SEGMENTS; i++) begin
         state_d.segment[i] = (32'(seg_value) > i);
      end
      state_d.full = (state_q.master == CODE_ONES);
      state_d.mid  = (state_q.master == CODE_MID);
      state_d.zero = (state_q.master == '0);

      // watch for a source clock slower than the lowest rate
      case (state_q.link)
         DAC_LINK_IDLE: begin
            state_d.gap_cnt = '0;
            if (clk_rise) begin
               state_d.link = DAC_LINK_RUN;
            end
         end
         DAC_LINK_RUN: begin
            if (clk_rise) begin
               state_d.gap_cnt = '0;
            end else if (state_q.gap_cnt == GAP_LAST) begin
               state_d.link = DAC_LINK_STALL;
            end else begin
               state_d.gap_cnt = state_q.gap_cnt + GAP_W'(1);
            end
         end
         DAC_LINK_STALL: begin
            state_d.gap_cnt = '0;
            if (clk_rise) begin
               state_d.link = DAC_LINK_RUN;
            end
         end
         default: begin
            state_d.link    = DAC_LINK_IDLE;
            state_d.gap_cnt = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   // word rests at zero scale, monitor waits for a first rise
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q.link     <= DAC_LINK_IDLE;
         state_q.clk_prev <= 1'b0;
         state_q.gap_cnt  <= '0;
         state_q.master   <= `DAC_CODE_RST;
         state_q.code     <= `DAC_CODE_RST;
         state_q.ladder   <= '0;
         state_q.segment  <= '0;
         state_q.full     <= 1'b0;
         state_q.mid      <= 1'b0;
         state_q.zero     <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign code_q        = state_q.code;
   assign ladder_q      = state_q.ladder;
   assign segment_q     = state_q.segment;
   assign full_scale_q  = state_q.full;
   assign mid_scale_q   = state_q.mid;
   assign zero_scale_q  = state_q.zero;
   assign link_active_q = (state_q.link == DAC_LINK_RUN);
   assign link_stall_q  = (state_q.link == DAC_LINK_STALL);

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking dac_cb @(posedge clk_sys);
   endclocking

   default disable iff (sys_rst);

   AST_CAPTURE_WORD: assert property (
      clk_rise |=> state_q.master == $past(data_in)
   ) else $error("master stage missed the word at the data clock rise");

   AST_MASTER_HOLDS: assert property (
      !clk_rise |=> $stable(state_q.master)
   ) else $error("master stage changed without a data clock rise");

   AST_CODE_PIPE: assert property (
      clk_rise ##1 !clk_rise |=> code_q == $past(data_in, 2)
   ) else $error("output word differs from the captured input word");

   AST_LADDER_DIRECT: assert property (
      clk_rise ##1 !clk_rise |=> ladder_q == $past(data_in[9:0], 2)
   ) else $error("ladder controls differ from low input bits");

   AST_SEG_COUNT: assert property (
      clk_rise ##1 !clk_rise |=> $countones(segment_q) == 32'($past(data_in[13:10], 2))
   ) else $error("segment count differs from upper input bits");

   AST_SEG_LOWEST: assert property (
      ((segment_q & (segment_q + SEG_ONE)) == '0)
      && ($countones(segment_q) == 32'(code_q[WIDTH-1:LADDER_BITS]))
   ) else $error("segment enables are not the lowest ones");

   AST_SCALE_FLAGS: assert property (
      (full_scale_q == (code_q == CODE_ONES))
      && (mid_scale_q == (code_q == CODE_MID))
      && (zero_scale_q == (code_q == '0))
   ) else $error("scale flags disagree with the output word");

   AST_FULL_ALL_ON: assert property (
      full_scale_q |-> (&segment_q) && (&ladder_q)
   ) else $error("full scale does not enable every switch");

   AST_STALL_TIMEOUT: assert property (
      link_active_q && !clk_rise && state_q.gap_cnt == GAP_LAST |=> link_stall_q
   ) else $error("slow source clock not flagged");

   AST_STALL_RECOVER: assert property (
      link_stall_q && clk_rise |=> link_active_q
   ) else $error("link did not resume on a data clock rise");

   AST_ZERO_ALL_OFF: assert property (
      zero_scale_q |-> (segment_q == '0) && (ladder_q == '0)
   ) else $error("zero scale leaves a switch enabled");

   AST_MID_HALF: assert property (
      mid_scale_q |-> ($countones(segment_q) == (SEGMENTS + 1) / 2) && (ladder_q == '0)
   ) else $error("midscale does not enable the lower half of the segments");

   AST_CODE_FROM_REG: assert property (
      $changed(code_q) |-> $past(clk_rise, 2) || $past(sys_rst)
   ) else $error("output word changed without a captured word");

   AST_RESET_IDLE: assert property (
      $fell(sys_rst) |-> zero_scale_q && !link_active_q && !link_stall_q
   ) else $error("outputs not at rest after reset");

   AST_STALL_AFTER_GAP: assert property (
      $rose(link_stall_q) |-> $past(state_q.gap_cnt) == GAP_LAST
   ) else $error("stall flagged before the full gap elapsed");

   COV_FULL_SCALE: cover property (full_scale_q);
   COV_MID_SCALE: cover property (mid_scale_q);
   COV_STALL: cover property (link_stall_q);
   COV_FAST_SOURCE: cover property (clk_rise ##2 clk_rise ##2 clk_rise);
   COV_STALL_RECOVER: cover property (link_stall_q ##1 link_active_q);

endmodule

`default_nettype wire

/* File: verification/dac_src.sv */
// sample source model driving the data clock and word
`timescale 1ns/10ps
`default_nettype none
module dac_src (
   input  wire logic        clk_sys,
   output logic             data_clk,
   output logic [13:0]      data_in
);
   initial begin
      data_clk = 1'b0;
      data_in  = 14'h0000;
   end
   // rise with word, stay high hi more cycles; word inverted once taken
   task automatic send(input logic [13:0] w, input int hi);
      @(posedge clk_sys) #1;
      data_clk = 1'b1;
      data_in  = w;
      repeat (hi) begin
         @(posedge clk_sys) #1;
         data_in = ~w;
      end
      @(posedge clk_sys) #1;
      data_clk = 1'b0;
      data_in  = ~w;
   endtask
endmodule
`default_nettype wire

/* File: verification/tb_dac_input_register_decoder.sv */
// testbench for the converter input register and decoder
`timescale 1ns/10ps
`default_nettype none
module tb_dac_input_register_decoder;
   import dac_pkg::*;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   wire logic   data_clk;
   wire logic [13:0] data_in;
   logic [13:0] code_q;
   logic [9:0]  ladder_q;
   logic [14:0] segment_q;
   logic        full_scale_q, mid_scale_q, zero_scale_q, link_active_q, link_stall_q;
   int          miscompares = 0;
   int          compares = 0;
   always #50 clk_sys = ~clk_sys;
   dac_src src (.clk_sys(clk_sys), .data_clk(data_clk), .data_in(data_in));
   dac_front dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .data_clk(data_clk),
      .data_in(data_in), .code_q(code_q), .ladder_q(ladder_q), .segment_q(segment_q),
      .full_scale_q(full_scale_q), .mid_scale_q(mid_scale_q),
      .zero_scale_q(zero_scale_q), .link_active_q(link_active_q),
      .link_stall_q(link_stall_q));
   task automatic summarize();
      if (miscompares == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk(input logic [13:0] w);
      logic [14:0] seg;
      seg = 15'((16'h0001 << w[13:10]) - 16'h0001);
      cmp(code_q, w);
      cmp(ladder_q, w[9:0]);
      cmp(segment_q, seg);
      cmp(full_scale_q, w == 14'h3fff);
      cmp(mid_scale_q, w == 14'h2000);
      cmp(zero_scale_q, w == 14'h0000);
   endtask
   task automatic t_reset();
      chk(14'h0000);
      cmp(link_active_q, 1'b0);
      cmp(link_stall_q, 1'b0);
      sys_rst = 1'b0;
      @(posedge clk_sys) #1;
      chk(14'h0000);
      cmp(link_active_q, 1'b0);
      cmp(link_stall_q, 1'b0);
   endtask
   task automatic t_sweep();
      logic [13:0] w;
      logic [13:0] fx [3] = '{14'h3fff, 14'h2000, 14'h0000};
      for (int n = 0; n < 16; n++) begin
         w = {n[3:0], 10'h2aa ^ {10{n[0]}}};
         src.send(w, 0);
         @(posedge clk_sys) #1;
         chk(w);
      end
      for (int k = 0; k < 3; k++) begin
         src.send(fx[k], 0);
         @(posedge clk_sys) #1;
         chk(fx[k]);
         @(posedge clk_sys) #1;
         cmp(code_q, fx[k]);
      end
   endtask
   task automatic t_hold();
      src.send(14'h1c35, 2);
      chk(14'h1c35);
   endtask
   task automatic t_stall();
      src.send(14'h0abc, 0);
      cmp(link_active_q, 1'b1);
      repeat (99) @(posedge clk_sys);
      #1;
      cmp(link_stall_q, 1'b0);
      @(posedge clk_sys) #1;
      cmp(link_stall_q, 1'b1);
      chk(14'h0abc);
      src.send(14'h2def, 0);
      cmp(link_stall_q, 1'b0);
      cmp(link_active_q, 1'b1);
      @(posedge clk_sys) #1;
      chk(14'h2def);
   endtask
   task automatic t_burst();
      logic [13:0] bw [3] = '{14'h0001, 14'h3c00, 14'h03ff};
      for (int k = 0; k < 3; k++) begin
         src.send(bw[k], 0);
         if (k > 0) chk(bw[k-1]);
      end
      @(posedge clk_sys) #1;
      chk(bw[2]);
   endtask
   task automatic t_rerst();
      sys_rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      t_reset();
      src.send(14'h2000, 0);
      @(posedge clk_sys) #1;
      chk(14'h2000);
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      t_reset();
      t_sweep();
      t_hold();
      t_stall();
      t_burst();
      t_rerst();
      summarize();
   end
   initial begin
      #200000;
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
